/* alio_pkg.sv */
// alio_pkg: constants and types for the arithmetic/logic and io-bit block.
// assumes nothing; imported by every design file of the block.
package alio_pkg;
    // ---------------------------------------------------------------------
    // status flag positions and reset values
    // ---------------------------------------------------------------------
    localparam int ALIO_FC = 0;
    localparam int ALIO_FZ = 1;
    localparam int ALIO_FN = 2;
    localparam int ALIO_FV = 3;
    localparam int ALIO_FS = 4;
    localparam int ALIO_FH = 5;
    localparam logic [7:0] ALIO_SREG_RST = 8'h00;
    localparam logic [7:0] ALIO_BYTE_RST = 8'h00;
    // ---------------------------------------------------------------------
    // data constants and io limits
    // ---------------------------------------------------------------------
    localparam logic [7:0] ALIO_ONES = 8'hFF;
    localparam logic [7:0] ALIO_ZERO = 8'h00;
    localparam logic [7:0] ALIO_MIN_NEG = 8'h80;
    localparam logic [7:0] ALIO_ONE = 8'h01;
    localparam logic [5:0] ALIO_IO_BIT_LO = 6'h00;
    localparam logic [5:0] ALIO_IO_BIT_HI = 6'h1F;
    localparam int ALIO_IO_SLOTS = 32;
    // ---------------------------------------------------------------------
    // cycle counts from accept to done
    // ---------------------------------------------------------------------
    localparam int ALIO_CYC_BYTE = 1;
    localparam int ALIO_CYC_WORD = 2;
    localparam int ALIO_CYC_IOBIT = 2;
    // ---------------------------------------------------------------------
    // operations and sequencer states
    // ---------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUB = 5'h02,
        OP_MINUS_CONST = 5'h03, OP_BORROW_MINUS_REG = 5'h04,
        OP_BORROW_MINUS_CONST = 5'h05, OP_AND = 5'h06,
        OP_MASK_CONST = 5'h07, OP_OR = 5'h08, OP_MERGE_CONST = 5'h09,
        OP_XOR_REGS = 5'h0A, OP_ONES_INVERT = 5'h0B,
        OP_TWOS_INVERT = 5'h0C, OP_BITSET_BY_MASK = 5'h0D,
        OP_BITCLEAR_BY_MASK = 5'h0E, OP_PLUS_ONE = 5'h0F,
        OP_WORD_IMMEDIATE_SUM = 5'h10, OP_WORD_IMMEDIATE_MINUS = 5'h11,
        OP_IO_BIT_SET = 5'h12, OP_IO_BIT_CLEAR = 5'h13,
        OP_IO_BIT_SKIP_IF_ONE = 5'h14, OP_IO_BIT_SKIP_IF_ZERO = 5'h15,
        OP_IO_READ = 5'h16, OP_IO_WRITE = 5'h17
    } alio_op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_WORD_HI = 2'b01, ST_IO_BIT = 2'b10
    } alio_state_t;
endpackage

/* alio_io_space.sv */
// alio_io_space: the 32 bit-accessible io byte registers.
// assumes one writer (byte or single bit) per cycle from the sequencer.
`timescale 1ns/1ns
`default_nettype none
module alio_io_space
    import alio_pkg::*;
#(
    parameter int SLOTS = ALIO_IO_SLOTS,
    parameter logic [8*ALIO_IO_SLOTS-1:0] FLAG_MASK = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // byte write
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    // single bit write
    input wire logic bit_en,
    input wire logic [4:0] bit_addr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    // hardware flag events
    input wire logic flag_set_valid,
    input wire logic [4:0] flag_set_addr,
    input wire logic [7:0] flag_set_bits,
    // read
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [SLOTS];

    assign rd_data = mem[rd_addr];

    // ---------------------------------------------------------------------
    // one register per entry
    // ---------------------------------------------------------------------
    for (genvar g = 0; g < SLOTS; g++) begin : g_slot
        localparam logic [7:0] M = FLAG_MASK[8*g +: 8];
        logic [7:0] next_val;
        logic [7:0] sel;
        // flag bits clear on a written one, plain bits take the data
        always_comb begin
            sel = ALIO_ONE << bit_sel;
            next_val = mem[g];
            if (wr_en && wr_addr == 5'(g)) begin
                next_val = (wr_data & ~M) | (mem[g] & M & ~wr_data);
            end else if (bit_en && bit_addr == 5'(g)) begin
                // only the addressed bit is touched
                next_val = (mem[g] & ~sel) | ({8{bit_val}} & sel & ~M)
                    | (mem[g] & sel & M & {8{~bit_val}});
            end
            if (flag_set_valid && flag_set_addr == 5'(g)) begin
                next_val = next_val | (flag_set_bits & M); // set wins
            end
        end
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                mem[g] <= ALIO_BYTE_RST;
            end else begin
                mem[g] <= next_val;
            end
        end
        AST_W1C_ZERO_KEEPS: assert property (@(posedge ref_clk)
            disable iff (sys_rst)
            (wr_en && wr_addr == 5'(g) && !flag_set_valid)
            |=> ((mem[g] & M & ~$past(wr_data))
                == ($past(mem[g]) & M & ~$past(wr_data))))
            else $error("flag bit changed by a zero write");
        AST_BIT_ONLY: assert property (@(posedge ref_clk)
            disable iff (sys_rst)
            (bit_en && bit_addr == 5'(g) && !flag_set_valid && !wr_en)
            |=> ((mem[g] & ~(ALIO_ONE << $past(bit_sel)))
                == ($past(mem[g]) & ~(ALIO_ONE << $past(bit_sel)))))
            else $error("bit operation touched another bit");
    end
endmodule // alio_io_space
`default_nettype wire

/* alio_core.sv */
// alio_core: 8-bit arithmetic/logic datapath with io single-bit access.
// assumes the decoder holds cmd_* steady while cmd_valid is high and idle.
//
// Overview of operation
// - Register add, and add with carry, set Z C N V H in one clock.
// - Word add of constant to register pair sets Z C N V S, two clocks.
// - Register subtract sets Z C N V H in one clock.
// - Subtract of constant sets Z C N V H in one clock.
// - Register subtract with borrow sets Z C N V H in one clock.
// - Constant subtract with borrow sets Z C N V H in one clock.
// - Word subtract of constant from pair sets Z C N V S, two clocks.
// - Register AND sets Z N V in one clock.
// - Constant AND sets Z N V in one clock.
// - Register OR sets Z N V in one clock.
// - Constant OR sets Z N V in one clock.
// - Register exclusive OR sets Z N V in one clock.
// - Bit set by mask ORs the mask in, sets Z N V, one clock.
// - Bit clear by mask ANDs with 0xFF minus mask, one clock.
// - Io single-bit set and clear only reach addresses 0x00 to 0x1F.
// - Io single-bit set or clear changes the addressed bit only.
// - Io bit test skips next instruction on set or clear bit.
// - Some io status flags clear on a written one; zero keeps them.
`timescale 1ns/1ns
`default_nettype none
module alio_core
    import alio_pkg::*;
#(
    parameter logic [8*ALIO_IO_SLOTS-1:0] FLAG_MASK = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // command
    input wire logic cmd_valid,
    input wire alio_op_t cmd_op,
    input wire logic [7:0] cmd_dst,
    input wire logic [7:0] cmd_src,
    input wire logic [7:0] cmd_imm,
    input wire logic [7:0] cmd_word_hi,
    input wire logic [5:0] cmd_io_addr,
    input wire logic [2:0] cmd_io_bit,
    // hardware flag events into io space
    input wire logic flag_set_valid,
    input wire logic [4:0] flag_set_addr,
    input wire logic [7:0] flag_set_bits,
    // answer
    output logic busy,
    output logic done,
    output logic [7:0] result,
    output logic [7:0] result_hi,
    output logic [7:0] sreg,
    output logic skip,
    output logic cmd_err
);
    alio_state_t state, next_state;
    logic accept, io_ok, carry_lo, hold_sub, hold_val;
    logic [7:0] io_rd, b, next_res, next_sreg, hold_hi, hold_lo;
    logic [8:0] wide, hi_wide;
    logic [4:0] hold_addr;
    logic [2:0] hold_bit;
    logic [15:0] word_res;

    // ---------------------------------------------------------------------
    // flag helpers
    // ---------------------------------------------------------------------
    function automatic logic [7:0] f_arith(input logic [7:0] x,
        input logic [7:0] y, input logic [7:0] r, input logic c,
        input logic sub, input logic keepz, input logic [7:0] old);
        logic [7:0] f;
        f = old;
        f[ALIO_FC] = c;
        f[ALIO_FN] = r[7];
        f[ALIO_FZ] = (r == ALIO_ZERO) && (!keepz || old[ALIO_FZ]);
        f[ALIO_FV] = sub ? (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7])
                         : (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
        f[ALIO_FH] = sub ? (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3])
                         : (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
        f[ALIO_FS] = f[ALIO_FN] ^ f[ALIO_FV];
        return f;
    endfunction

    function automatic logic [7:0] f_logic(input logic [7:0] r,
        input logic v, input logic [7:0] old);
        logic [7:0] f;
        f = old;
        f[ALIO_FN] = r[7];
        f[ALIO_FZ] = (r == ALIO_ZERO);
        f[ALIO_FV] = v;
        f[ALIO_FS] = r[7] ^ v;
        return f;
    endfunction

    // ---------------------------------------------------------------------
    // io space
    // ---------------------------------------------------------------------
    assign accept = cmd_valid && state == ST_IDLE;
    assign io_ok = cmd_io_addr <= ALIO_IO_BIT_HI;

    // a reserved slot is stored like any other; software keeps off it
    alio_io_space #(.SLOTS(ALIO_IO_SLOTS), .FLAG_MASK(FLAG_MASK)) u_io (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_en(accept && cmd_op == OP_IO_WRITE && io_ok),
        .wr_addr(cmd_io_addr[4:0]),
        .wr_data(cmd_dst),
        .bit_en(state == ST_IO_BIT),
        .bit_addr(hold_addr),
        .bit_sel(hold_bit),
        .bit_val(hold_val),
        .flag_set_valid(flag_set_valid),
        .flag_set_addr(flag_set_addr),
        .flag_set_bits(flag_set_bits),
        .rd_addr(cmd_io_addr[4:0]),
        .rd_data(io_rd)
    );

    // ---------------------------------------------------------------------
    // byte datapath, one clock
    // ---------------------------------------------------------------------
    always_comb begin
        b = cmd_src;
        if (cmd_op inside {OP_MINUS_CONST, OP_BORROW_MINUS_CONST,
            OP_MASK_CONST, OP_MERGE_CONST, OP_BITSET_BY_MASK,
            OP_BITCLEAR_BY_MASK}) begin
            b = cmd_imm;
        end
        wide = '0;
        next_res = cmd_dst;
        next_sreg = sreg;
        case (cmd_op)
            OP_ADD, OP_ADC: begin
                wide = {1'b0, cmd_dst} + {1'b0, b}
                    + {8'h00, sreg[ALIO_FC] & (cmd_op == OP_ADC)};
                next_res = wide[7:0];
                next_sreg = f_arith(cmd_dst, b, next_res, wide[8], 1'b0,
                    1'b0, sreg);
            end
            OP_SUB, OP_MINUS_CONST: begin
                wide = {1'b0, cmd_dst} - {1'b0, b};
                next_res = wide[7:0];
                next_sreg = f_arith(cmd_dst, b, next_res, wide[8], 1'b1,
                    1'b0, sreg);
            end
            OP_BORROW_MINUS_REG, OP_BORROW_MINUS_CONST: begin
                wide = {1'b0, cmd_dst} - {1'b0, b}
                    - {8'h00, sreg[ALIO_FC]};
                next_res = wide[7:0];
                next_sreg = f_arith(cmd_dst, b, next_res, wide[8], 1'b1,
                    1'b1, sreg);
            end
            OP_AND, OP_MASK_CONST: begin
                next_res = cmd_dst & b;
                next_sreg = f_logic(next_res, 1'b0, sreg);
            end
            OP_OR, OP_MERGE_CONST, OP_BITSET_BY_MASK: begin
                next_res = cmd_dst | b;
                next_sreg = f_logic(next_res, 1'b0, sreg);
            end
            OP_XOR_REGS: begin
                next_res = cmd_dst ^ cmd_src;
                next_sreg = f_logic(next_res, 1'b0, sreg);
            end
            OP_BITCLEAR_BY_MASK: begin
                next_res = cmd_dst & (ALIO_ONES - b);
                next_sreg = f_logic(next_res, 1'b0, sreg);
            end
            OP_ONES_INVERT: begin
                next_res = ALIO_ONES - cmd_dst;
                next_sreg = f_logic(next_res, 1'b0, sreg);
                next_sreg[ALIO_FC] = 1'b1;
            end
            OP_TWOS_INVERT: begin
                wide = {1'b0, ALIO_ZERO} - {1'b0, cmd_dst};
                next_res = wide[7:0];
                next_sreg = f_arith(ALIO_ZERO, cmd_dst, next_res, wide[8],
                    1'b1, 1'b0, sreg);
            end
            OP_PLUS_ONE: begin
                next_res = cmd_dst + ALIO_ONE;
                next_sreg = f_logic(next_res, next_res == ALIO_MIN_NEG, sreg);
            end
            OP_IO_READ: next_res = io_ok ? io_rd : ALIO_ZERO;
            default: next_res = cmd_dst;
        endcase
    end

    // word datapath, high byte in the second clock
    always_comb begin
        hi_wide = hold_sub ? {1'b0, hold_hi} - {8'h00, carry_lo}
                           : {1'b0, hold_hi} + {8'h00, carry_lo};
        word_res = {hi_wide[7:0], hold_lo};
    end

    // ---------------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept && (cmd_op == OP_WORD_IMMEDIATE_SUM
                    || cmd_op == OP_WORD_IMMEDIATE_MINUS)) begin
                    next_state = ST_WORD_HI;
                end else if (accept && io_ok && (cmd_op == OP_IO_BIT_SET
                    || cmd_op == OP_IO_BIT_CLEAR)) begin
                    next_state = ST_IO_BIT;
                end
            end
            ST_WORD_HI, ST_IO_BIT: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_state != ST_IDLE;
        end
    end

    // operands held across a two-clock operation
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hold_hi <= ALIO_BYTE_RST;
            hold_lo <= ALIO_BYTE_RST;
            hold_sub <= 1'b0;
            carry_lo <= 1'b0;
            hold_addr <= '0;
            hold_bit <= '0;
            hold_val <= 1'b0;
        end else if (accept) begin
            hold_hi <= cmd_word_hi;
            hold_sub <= cmd_op == OP_WORD_IMMEDIATE_MINUS;
            if (cmd_op == OP_WORD_IMMEDIATE_MINUS) begin
                {carry_lo, hold_lo} <= {1'b0, cmd_dst}
                    - {3'b000, cmd_imm[5:0]};
            end else begin
                {carry_lo, hold_lo} <= {1'b0, cmd_dst}
                    + {3'b000, cmd_imm[5:0]};
            end
            hold_addr <= cmd_io_addr[4:0];
            hold_bit <= cmd_io_bit;
            hold_val <= cmd_op == OP_IO_BIT_SET;
        end
    end

    // answer registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            done <= 1'b0;
            result <= ALIO_BYTE_RST;
            result_hi <= ALIO_BYTE_RST;
            sreg <= ALIO_SREG_RST;
            skip <= 1'b0;
            cmd_err <= 1'b0;
        end else begin
            done <= (accept && next_state == ST_IDLE) || state != ST_IDLE;
            if (state == ST_WORD_HI) begin
                result <= word_res[7:0];
                result_hi <= word_res[15:8];
                sreg[ALIO_FN] <= word_res[15];
                sreg[ALIO_FZ] <= word_res == 16'h0000;
                sreg[ALIO_FV] <= hold_sub ? hold_hi[7] & ~word_res[15]
                                          : ~hold_hi[7] & word_res[15];
                sreg[ALIO_FC] <= hold_sub ? word_res[15] & ~hold_hi[7]
                                          : ~word_res[15] & hold_hi[7];
                sreg[ALIO_FS] <= word_res[15] ^ (hold_sub
                    ? hold_hi[7] & ~word_res[15]
                    : ~hold_hi[7] & word_res[15]);
            end else if (accept) begin
                result <= next_res;
                sreg <= next_sreg;
                // a one bit skips for the if-one variant, zero for if-zero
                skip <= io_ok && ((cmd_op == OP_IO_BIT_SKIP_IF_ONE
                    && io_rd[cmd_io_bit])
                    || (cmd_op == OP_IO_BIT_SKIP_IF_ZERO
                    && !io_rd[cmd_io_bit]));
                cmd_err <= !io_ok && cmd_op inside {OP_IO_BIT_SET,
                    OP_IO_BIT_CLEAR, OP_IO_BIT_SKIP_IF_ONE,
                    OP_IO_BIT_SKIP_IF_ZERO, OP_IO_READ,
                    OP_IO_WRITE};
            end
        end
    end

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    AST_ADD_ONE_CLOCK: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && cmd_op == OP_ADD)
        |=> done && result == 8'($past(cmd_dst) + $past(cmd_src)))
        else $error("register add wrong or late");
    AST_SUB_ONE_CLOCK: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && cmd_op == OP_SUB)
        |=> done && result == 8'($past(cmd_dst) - $past(cmd_src))
            && sreg[ALIO_FC] == ($past(cmd_src) > $past(cmd_dst)))
        else $error("register subtract wrong");
    AST_WORD_SUM_TWO: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && cmd_op == OP_WORD_IMMEDIATE_SUM)
        |=> busy && !done ##1 done && {result_hi, result}
            == 16'({$past(cmd_word_hi, 2), $past(cmd_dst, 2)}
                + {10'h000, $past(cmd_imm[5:0], 2)}))
        else $error("word sum wrong or not two clocks");
    AST_WORD_MINUS_TWO: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && cmd_op == OP_WORD_IMMEDIATE_MINUS)
        |-> ##2 done && {result_hi, result}
            == 16'({$past(cmd_word_hi, 2), $past(cmd_dst, 2)}
                - {10'h000, $past(cmd_imm[5:0], 2)}))
        else $error("word subtract wrong or not two clocks");
    AST_AND_CLEARS_V: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && cmd_op == OP_AND)
        |=> !sreg[ALIO_FV] && sreg[ALIO_FC] == $past(sreg[ALIO_FC])
            && sreg[ALIO_FZ] == (result == ALIO_ZERO))
        else $error("and flags wrong");
    AST_CLEAR_BY_MASK: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && cmd_op == OP_BITCLEAR_BY_MASK)
        |=> (result & $past(cmd_imm)) == ALIO_ZERO)
        else $error("masked bit left set");
    AST_IO_RANGE: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && !io_ok
            && cmd_op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR})
        |=> cmd_err && done && state == ST_IDLE)
        else $error("bit operation beyond 0x1F accepted");
    AST_SKIP_ONE: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && io_ok
            && cmd_op == OP_IO_BIT_SKIP_IF_ONE)
        |=> skip == $past(io_rd[cmd_io_bit]))
        else $error("skip decision wrong");
    AST_IO_BIT_TWO: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (accept && io_ok
            && cmd_op == OP_IO_BIT_SET)
        |=> busy ##1 done && !busy)
        else $error("io bit set not two clocks");
endmodule // alio_core
`default_nettype wire

/* arith_logic_and_io_bit_ops_test.sv */
// testbench for alio_core: byte and word arithmetic, logic ops, io bits.
// assumes alio_pkg is compiled first; drives every input itself.
`timescale 1ns/1ns
`default_nettype none
module arith_logic_and_io_bit_ops_test import alio_pkg::*; ;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    alio_op_t cmd_op = OP_ADD;
    logic [7:0] cmd_dst = 8'h00, cmd_src = 8'h00, cmd_imm = 8'h00;
    logic [7:0] cmd_word_hi = 8'h00;
    logic [5:0] cmd_io_addr = 6'h00;
    logic [2:0] cmd_io_bit = 3'h0;
    logic flag_set_valid = 1'b0;
    logic [4:0] flag_set_addr = 5'h00;
    logic [7:0] flag_set_bits = 8'h00;
    logic busy, done, skip, cmd_err;
    logic [7:0] result, result_hi, sreg;
    int err_total = 0, n_checks = 0, cyc = 0;
    alio_op_t lop [7] = '{OP_AND, OP_MASK_CONST, OP_OR, OP_MERGE_CONST,
        OP_XOR_REGS, OP_BITSET_BY_MASK, OP_BITCLEAR_BY_MASK};
    logic [7:0] lres [7] = '{8'h00, 8'h81, 8'hFF, 8'hC3, 8'hFF, 8'hC3,
        8'h42};
    // io slot 3 holds write-one-to-clear flags in bits 7 and 0
    alio_core #(.FLAG_MASK({224'h0, 8'h81, 24'h0})) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_dst(cmd_dst), .cmd_src(cmd_src),
        .cmd_imm(cmd_imm), .cmd_word_hi(cmd_word_hi),
        .cmd_io_addr(cmd_io_addr), .cmd_io_bit(cmd_io_bit),
        .flag_set_valid(flag_set_valid), .flag_set_addr(flag_set_addr),
        .flag_set_bits(flag_set_bits), .busy(busy), .done(done),
        .result(result), .result_hi(result_hi), .sreg(sreg),
        .skip(skip), .cmd_err(cmd_err));
    // ---------------------------------------------------------------
    // clock, timeout and shared tasks
    // ---------------------------------------------------------------
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // cut a hang short well beyond the hundred or so cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // offer one command, then check the clocks from accept to done
    task automatic op(input alio_op_t o, input logic [7:0] d, s, k, h,
                      input logic [5:0] a, input logic [2:0] b, int n);
        int c;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        {cmd_dst, cmd_src, cmd_imm, cmd_word_hi} <= {d, s, k, h};
        {cmd_io_addr, cmd_io_bit} <= {a, b};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        c = 1;
        #1;
        chk(16'(busy), 16'(n == 2));
        while (done !== 1'b1 && c < 8) begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        chk(16'(c), 16'(n));
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        op(OP_IO_READ, 8'h00, 8'h00, 8'h00, 8'h00, a, 3'h0, 1);
        chk({8'h00, result}, {8'h00, e});
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_word();
        op(OP_WORD_IMMEDIATE_SUM, 8'hFF, 8'h00, 8'hC1, 8'h7F, 0, 0, 2);
        chk({result_hi, result}, 16'h8000);
        chk({8'h00, sreg}, 16'h000C);
        op(OP_WORD_IMMEDIATE_MINUS, 8'h00, 8'h00, 8'h01, 8'h00, 0, 0, 2);
        chk({result_hi, result}, 16'hFFFF);
        chk({8'h00, sreg}, 16'h0015);
    endtask
    task automatic t_arith();
        op(OP_ADD, 8'h0F, 8'h01, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h1020);
        op(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h0023);
        op(OP_ADC, 8'h10, 8'h20, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h3100);
        op(OP_SUB, 8'h10, 8'h01, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h0F20);
        op(OP_MINUS_CONST, 8'h80, 8'h00, 8'h01, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h7F38);
    endtask
    // zero flag survives a borrow subtract only when it was already set
    task automatic t_borrow();
        op(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 0, 0, 1);
        op(OP_BORROW_MINUS_CONST, 8'h01, 8'h00, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h0002);
        op(OP_SUB, 8'h00, 8'h01, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'hFF35);
        op(OP_BORROW_MINUS_REG, 8'h05, 8'h04, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h0000);
    endtask
    // logic ops keep carry and half carry, which are set beforehand
    task automatic t_logic();
        logic [7:0] r;
        op(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 0, 0, 1);
        for (int i = 0; i < 7; i++) begin
            r = lres[i];
            op(lop[i], 8'hC3, 8'h3C, 8'h81, 8'h00, 0, 0, 1);
            chk({result, sreg}, {r, 3'b001, r[7], 1'b0, r[7], r == 8'h00,
                1'b1});
        end
        op(OP_ONES_INVERT, 8'h55, 8'h00, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'hAA35);
        op(OP_TWOS_INVERT, 8'h80, 8'h00, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h800D);
        op(OP_PLUS_ONE, 8'h7F, 8'h00, 8'h00, 8'h00, 0, 0, 1);
        chk({result, sreg}, 16'h800D);
    endtask
    task automatic t_io();
        op(OP_IO_WRITE, 8'h5A, 8'h00, 8'h00, 8'h00, 6'h05, 3'h0, 1);
        op(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 6'h05, 3'h0, 2);
        op(OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 8'h00, 6'h05, 3'h6, 2);
        rd(6'h05, 8'h1B);
        op(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 6'h1F, 3'h7, 2);
        rd(6'h1F, 8'h80);
        op(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 6'h25, 3'h7, 1);
        chk({15'h0000, cmd_err}, 16'h0001);
        rd(6'h05, 8'h1B);
        op(OP_IO_BIT_SKIP_IF_ONE, 8'h00, 8'h00, 8'h00, 8'h00, 6'h05, 0, 1);
        chk({7'h00, skip, 7'h00, cmd_err}, 16'h0100);
        op(OP_IO_BIT_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 8'h00, 6'h05, 0, 1);
        chk({7'h00, skip, 7'h00, cmd_err}, 16'h0000);
        op(OP_IO_BIT_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 8'h00, 6'h05, 2, 1);
        chk({7'h00, skip, 7'h00, cmd_err}, 16'h0100);
    endtask
    // hardware raises flags in slot 3; only masked bits may take them
    task automatic t_flags();
        @(posedge ref_clk);
        {flag_set_valid, flag_set_addr, flag_set_bits} <= {1'b1, 5'h03, 8'hFF};
        @(posedge ref_clk);
        flag_set_valid <= 1'b0;
        rd(6'h03, 8'h81);
        op(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 6'h03, 3'h1, 2);
        rd(6'h03, 8'h83);
        op(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 6'h03, 3'h0, 2);
        op(OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 8'h00, 6'h03, 3'h7, 2);
        rd(6'h03, 8'h82);
        op(OP_IO_WRITE, 8'h02, 8'h00, 8'h00, 8'h00, 6'h03, 3'h0, 1);
        rd(6'h03, 8'h82);
        op(OP_IO_WRITE, 8'h80, 8'h00, 8'h00, 8'h00, 6'h03, 3'h0, 1);
        rd(6'h03, 8'h00);
    endtask
    // ---------------------------------------------------------------
    // main sequence: word test first, while half carry is still reset
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_word();
        t_arith();
        t_borrow();
        t_logic();
        t_io();
        t_flags();
        test_done();
    end
endmodule // arith_logic_and_io_bit_ops_test
`default_nettype wire
